// [core/ivr_pkg.sv]
// Notes on behaviour
// - With the select bit clear the vectors come from the start of flash, with it set from the start of the boot section.
// - The boot section start, and so the relocated vector base, follows the boot size fuses.
// - Interrupts are held off from the cycle change enable is set until the instruction after the select write has completed.
// - If the select bit is never written, the hold-off lasts four cycles and then ends.
// - The automatic hold-off never alters the global interrupt enable flag.
// - With vectors in the boot section and the application lock fuse programmed, interrupts are off while running application code.
// - With vectors in the application section and the boot lock fuse programmed, interrupts are off while running boot code.
// - Hardware clears change enable four cycles after it is written, or at once when the select bit is written.
// - Boot reset fuse unprogrammed, 4 Kbyte boot section, select set: reset at word 0, first vector at word 3802h.
// - Boot reset fuse programmed, 4 Kbyte boot section, select clear: reset at word 3800h, vectors from word 002h.
// - Boot reset fuse programmed, 4 Kbyte boot section, select set: reset at word 3800h, first vector at word 3802h.
// - A relocated vector address is its application table address plus the boot section start.
package ivr_pkg;

  // program counter and vector addresses are flash word addresses
  localparam int ADDR_W = 14;
  localparam int VEC_IDX_W = 5;
  localparam int SIZE_W = 2;

  // apb map, byte addresses
  localparam logic [7:0] GIC_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;

  // general interrupt control fields
  localparam int CE_BIT = 0;
  localparam int SEL_BIT = 1;
  localparam int EXT_LO_BIT = 5;
  localparam int EXT_HI_BIT = 7;
  localparam logic [7:0] GIC_RESET = 8'h00;

  // status register fields
  localparam int ST_WINDOW_BIT = 0;
  localparam int ST_HOLD_BIT = 1;
  localparam int ST_LOCK_BIT = 2;
  localparam int ST_SEL_BIT = 3;
  localparam int ST_SIZE_LO_BIT = 4;
  localparam int ST_SIZE_HI_BIT = 5;
  localparam int ST_BOOT_RESET_FUSE_BIT = 6;
  localparam int ST_VALID_BIT = 7;

  // change window length in clock cycles
  localparam logic [2:0] CHANGE_WINDOW_CYCLES = 3'h4;

  // boot section geometry: size code 0 is the largest (4 Kbyte, 2048 words)
  localparam logic [ADDR_W-1:0] BOOT_WORDS_MAX = 14'h0800;
  localparam logic [ADDR_W-1:0] FIRST_VECTOR = 14'h0002;
  localparam logic [ADDR_W-1:0] APP_RESET_ADDR = 14'h0000;
  localparam int SLOT_SHIFT = 1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WINDOW = 3'b010,
    ST_HOLD = 3'b100
  } ivr_state_type;

  // the boot section always ends at the top of flash
  function automatic logic [ADDR_W-1:0] ivr_boot_start(input logic [SIZE_W-1:0] size_code);
    ivr_boot_start = APP_RESET_ADDR - (BOOT_WORDS_MAX >> size_code);
  endfunction

endpackage

// [core/ivr_strap_sync.sv]
`timescale 1ns/10ps
`default_nettype none
// three-flop synchroniser for static fuse levels; a value is taken once
// the second and third stages agree, so a glitch seen at one clock edge only never lands
module ivr_strap_sync
  import ivr_pkg::*;
#(
  parameter int W = 5
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [W-1:0] raw_in,
  output logic [W-1:0] value_out,
  output logic valid_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [2:0] fill;
    logic [W-1:0] value;
    logic valid;
  } ivr_sync_type;

  ivr_sync_type st;
  ivr_sync_type next_st;

  // first stage only feeds the second; the fill chain stops the all-zero
  // reset contents of the stages from passing as an agreed sample, which
  // would read as every fuse programmed for a few cycles after reset
  always_comb begin
    next_st = st;
    next_st.s1 = raw_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.fill = {st.fill[1:0], 1'b1};
    if (st.fill[2] && (st.s2 == st.s3)) begin
      next_st.value = st.s3;
      next_st.valid = 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign value_out = st.value;
  assign valid_out = st.valid;

endmodule
`default_nettype wire

// [core/ivr_vector_addr.sv]
`timescale 1ns/10ps
`default_nettype none
// registered address arithmetic for the core's fetch unit
module ivr_vector_addr
  import ivr_pkg::*;
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic vector_table_select_in,
  input wire logic boot_reset_prog_in,
  input wire logic [SIZE_W-1:0] boot_size_in,
  input wire logic [VEC_IDX_W-1:0] vector_index_in,
  output logic [ADDR_W-1:0] reset_addr_out,
  output logic [ADDR_W-1:0] vector_base_out,
  output logic [ADDR_W-1:0] vector_addr_out
);

  typedef struct packed {
    logic [ADDR_W-1:0] reset_addr;
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] vec;
  } ivr_addr_type;

  ivr_addr_type st;
  ivr_addr_type next_st;
  logic [ADDR_W-1:0] boot_start;

  always_comb begin
    boot_start = ivr_boot_start(boot_size_in);
    next_st = st;
    // reset entry follows the boot reset fuse and the boot size, not the select bit
    next_st.reset_addr = boot_reset_prog_in ? boot_start : APP_RESET_ADDR;
    // table base moves with the select bit
    next_st.base = vector_table_select_in ? boot_start : APP_RESET_ADDR;
    // slot n sits two words per entry past the reset slot, offset by the base
    next_st.vec = next_st.base
                  + (ADDR_W'(vector_index_in) << SLOT_SHIFT)
                  + FIRST_VECTOR;
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reset_addr_out = st.reset_addr;
  assign vector_base_out = st.base;
  assign vector_addr_out = st.vec;

endmodule
`default_nettype wire

// [core/ivr_vector_ctrl.sv]
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
// interrupt vector placement control with a timed two-write change sequence.
// the core sees one apb slave with the general interrupt control register and
// a read-only status word; interrupt gating is done here and handed back to
// the core as a single permit, the core's own global enable is only read.
module ivr_vector_ctrl
  import ivr_pkg::*;
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fuse pins, raw levels, zero means programmed
  input wire logic boot_reset_fuse_n_in,
  input wire logic [SIZE_W-1:0] boot_size_fuses_in,
  input wire logic app_section_boot_lock_n_in,
  input wire logic boot_section_self_lock_n_in,
  // core side, same clock
  input wire logic [ADDR_W-1:0] pc_in,
  input wire logic instr_done_in,
  input wire logic global_int_enable_in,
  input wire logic [VEC_IDX_W-1:0] vector_index_in,
  // outputs to the core
  output logic irq_permit_out,
  output logic change_holdoff_out,
  output logic vector_table_select_out,
  output logic [2:0] ext_int_enable_out,
  output logic [ADDR_W-1:0] reset_addr_out,
  output logic [ADDR_W-1:0] vector_base_out,
  output logic [ADDR_W-1:0] vector_addr_out
);

  localparam int FUSE_W = SIZE_W + 3;

  typedef struct packed {
    ivr_state_type state;
    logic [2:0] window_cnt;
    logic change_enable;
    logic table_select;
    logic [2:0] ext_enable;
    logic [31:0] rdata;
    logic [ADDR_W-1:0] boot_start;
    logic in_boot;
  } ivr_ctrl_type;

  ivr_ctrl_type st;
  ivr_ctrl_type next_st;

  logic [FUSE_W-1:0] fuse_raw;
  logic [FUSE_W-1:0] fuse_val;
  logic fuse_valid;
  logic boot_reset_prog;
  logic app_lock_prog;
  logic boot_lock_prog;
  logic [SIZE_W-1:0] boot_size;
  logic setup_phase;
  logic access_phase;
  logic hit_gic;
  logic hit_status;
  logic gic_write;
  logic ce_written_one;
  logic lock_block;
  logic holdoff;
  logic [7:0] gic_view;
  logic [7:0] status_view;

  // fuse pins come from outside the clock domain
  assign fuse_raw = {boot_reset_fuse_n_in,
                     app_section_boot_lock_n_in,
                     boot_section_self_lock_n_in,
                     boot_size_fuses_in};

  ivr_strap_sync #(
    .W(FUSE_W)
  ) u_fuse_sync (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .raw_in(fuse_raw),
    .value_out(fuse_val),
    .valid_out(fuse_valid)
  );

  // programmed fuses read as zero; until the first agreed sample the boot reset
  // and lock fuses count as unprogrammed so no lock gates interrupts spuriously
  assign boot_reset_prog = fuse_valid & ~fuse_val[FUSE_W-1];
  assign app_lock_prog = fuse_valid & ~fuse_val[FUSE_W-2];
  assign boot_lock_prog = fuse_valid & ~fuse_val[FUSE_W-3];
  assign boot_size = fuse_val[SIZE_W-1:0];

  // apb decode, zero wait states
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign hit_gic = (paddr == GIC_OFFSET);
  assign hit_status = (paddr == STATUS_OFFSET);
  assign gic_write = access_phase & pwrite & hit_gic;
  assign ce_written_one = gic_write & pwdata[CE_BIT];
  assign pready = 1'b1;

  // unmapped addresses and writes to the status word are errors
  always_comb begin
    if (!access_phase) begin
      pslverr = 1'b0;
    end else if (hit_gic) begin
      pslverr = 1'b0;
    end else if (hit_status) begin
      pslverr = pwrite;
    end else begin
      pslverr = 1'b1;
    end
  end

  // register views; unused bits read as zero
  always_comb begin
    gic_view = GIC_RESET;
    gic_view[EXT_HI_BIT:EXT_LO_BIT] = st.ext_enable;
    gic_view[SEL_BIT] = st.table_select;
    gic_view[CE_BIT] = st.change_enable;
    status_view = 8'h00;
    status_view[ST_WINDOW_BIT] = (st.state == ST_WINDOW);
    status_view[ST_HOLD_BIT] = holdoff;
    status_view[ST_LOCK_BIT] = lock_block;
    status_view[ST_SEL_BIT] = st.table_select;
    status_view[ST_SIZE_HI_BIT:ST_SIZE_LO_BIT] = boot_size;
    status_view[ST_BOOT_RESET_FUSE_BIT] = boot_reset_prog;
    status_view[ST_VALID_BIT] = fuse_valid;
  end

  // hold-off is on in the very cycle change enable is written, before the
  // register has caught up, so no interrupt slips in between the writes
  assign holdoff = (st.state != ST_IDLE) | ce_written_one;

  // section locks: running from the section whose table is not in use
  assign lock_block = (st.table_select & app_lock_prog & ~st.in_boot)
                      | (~st.table_select & boot_lock_prog & st.in_boot);

  // the global enable is only gated here, never written back
  assign irq_permit_out = global_int_enable_in & ~holdoff & ~lock_block;
  assign change_holdoff_out = holdoff;
  assign vector_table_select_out = st.table_select;
  assign ext_int_enable_out = st.ext_enable;
  assign prdata = st.rdata;

  // sequence machine and register file
  always_comb begin
    next_st = st;
    next_st.boot_start = ivr_boot_start(boot_size);
    next_st.in_boot = (pc_in >= st.boot_start);

    // read data is captured in setup so it comes from a flop in access
    if (setup_phase && !pwrite) begin
      if (hit_gic) begin
        next_st.rdata = {24'h000000, gic_view};
      end else if (hit_status) begin
        next_st.rdata = {24'h000000, status_view};
      end else begin
        next_st.rdata = 32'h00000000;
      end
    end

    // external enable bits are plain storage for the core
    if (gic_write) begin
      next_st.ext_enable = pwdata[EXT_HI_BIT:EXT_LO_BIT];
    end

    case (st.state)
      ST_IDLE: begin
        if (ce_written_one) begin
          // arm the window; the select value in this write is not taken
          next_st.state = ST_WINDOW;
          next_st.change_enable = 1'b1;
          next_st.window_cnt = CHANGE_WINDOW_CYCLES - 3'h1;
        end
      end
      ST_WINDOW: begin
        if (ce_written_one) begin
          // another arming write restarts the full window
          next_st.change_enable = 1'b1;
          next_st.window_cnt = CHANGE_WINDOW_CYCLES - 3'h1;
        end else if (gic_write) begin
          // second write of the sequence: take select, drop enable at once
          next_st.table_select = pwdata[SEL_BIT];
          next_st.change_enable = 1'b0;
          next_st.window_cnt = 3'h0;
          next_st.state = ST_HOLD;
        end else if (st.window_cnt == 3'h1) begin
          // four cycles since the arming write with no select write
          next_st.change_enable = 1'b0;
          next_st.window_cnt = 3'h0;
          next_st.state = ST_IDLE;
        end else begin
          next_st.window_cnt = st.window_cnt - 3'h1;
        end
      end
      ST_HOLD: begin
        // stay off until the instruction after the select write retires
        if (ce_written_one) begin
          next_st.state = ST_WINDOW;
          next_st.change_enable = 1'b1;
          next_st.window_cnt = CHANGE_WINDOW_CYCLES - 3'h1;
        end else if (instr_done_in) begin
          next_st.state = ST_IDLE;
        end
      end
      default: begin
        next_st.state = ST_IDLE;
        next_st.change_enable = 1'b0;
        next_st.window_cnt = 3'h0;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st.state <= ST_IDLE;
      st.window_cnt <= 3'h0;
      st.change_enable <= GIC_RESET[CE_BIT];
      st.table_select <= GIC_RESET[SEL_BIT];
      st.ext_enable <= GIC_RESET[EXT_HI_BIT:EXT_LO_BIT];
      st.rdata <= 32'h00000000;
      st.boot_start <= '0;
      st.in_boot <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // address arithmetic for reset entry and vector fetch
  ivr_vector_addr u_vec (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .vector_table_select_in(st.table_select),
    .boot_reset_prog_in(boot_reset_prog),
    .boot_size_in(boot_size),
    .vector_index_in(vector_index_in),
    .reset_addr_out(reset_addr_out),
    .vector_base_out(vector_base_out),
    .vector_addr_out(vector_addr_out)
  );

endmodule
`default_nettype wire

// [verification/ivr_props.sv]
`timescale 1ns/10ps
`default_nettype none
// pin-level checks of the control block; they rely on the zero-wait apb answer
module ivr_checker
  import ivr_pkg::*;
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic instr_done_in,
  input wire logic global_int_enable_in,
  input wire logic [VEC_IDX_W-1:0] vector_index_in,
  input wire logic irq_permit_out,
  input wire logic change_holdoff_out,
  input wire logic vector_table_select_out,
  input wire logic [ADDR_W-1:0] vector_base_out,
  input wire logic [ADDR_W-1:0] vector_addr_out
);
  logic ctrl_wr;
  // a write to the control register committing at this edge
  assign ctrl_wr = psel && penable && pwrite && (paddr == GIC_OFFSET);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // arming write, then four edges with no control write at all
  sequence s_arm;
    ctrl_wr && pwdata[CE_BIT];
  endsequence
  sequence s_quiet;
    (!ctrl_wr)[*4];
  endsequence
  a_arm_holds: assert property (s_arm |-> change_holdoff_out ##1 change_holdoff_out)
    else $error("holdoff missing after arming write");
  a_window_ends: assert property (s_arm ##1 s_quiet |-> !change_holdoff_out && $past(change_holdoff_out))
    else $error("unused change window did not end after four cycles");
  a_hold_blocks: assert property (change_holdoff_out |-> !irq_permit_out)
    else $error("interrupt permitted during holdoff");
  a_gie_kept: assert property (!global_int_enable_in |-> !irq_permit_out)
    else $error("interrupt permitted with global enable low");
  a_sel_guarded: assert property ($changed(vector_table_select_out) |-> $past(change_holdoff_out))
    else $error("select moved outside a change sequence");
  a_select_holds: assert property ($changed(vector_table_select_out) && !instr_done_in |=> change_holdoff_out)
    else $error("holdoff dropped before next instruction");
  a_select_release: assert property ($changed(vector_table_select_out) ##1 (instr_done_in && !ctrl_wr) |=> !change_holdoff_out)
    else $error("holdoff kept after next instruction");
  a_addr_offset: assert property ($past(resetn_in) |-> vector_addr_out == vector_base_out + ADDR_W'({$past(vector_index_in), 1'b0}) + 14'h0002)
    else $error("vector address not base plus slot offset");
  a_base_app: assert property ($past(resetn_in) && !$past(vector_table_select_out) |-> vector_base_out == 14'h0000)
    else $error("vector base not at flash start");
  a_bad_addr: assert property (psel && penable && (paddr != GIC_OFFSET) && (paddr != STATUS_OFFSET) |-> pslverr)
    else $error("unmapped access not refused");
endmodule
bind ivr_vector_ctrl ivr_checker u_ivr_checker (
  .mclk_in(mclk_in), .resetn_in(resetn_in), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .instr_done_in(instr_done_in),
  .global_int_enable_in(global_int_enable_in), .vector_index_in(vector_index_in),
  .irq_permit_out(irq_permit_out), .change_holdoff_out(change_holdoff_out),
  .vector_table_select_out(vector_table_select_out), .vector_base_out(vector_base_out),
  .vector_addr_out(vector_addr_out)
);
`default_nettype wire

// [verification/interrupt_vector_relocation_test.sv]
`timescale 1ns/10ps
`default_nettype none
module interrupt_vector_relocation_test
  import ivr_pkg::*;
;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, permit, holdoff, sel;
  logic brst_n = 1'b1, alock_n = 1'b1, block_n = 1'b1, idone = 1'b0, gie = 1'b1;
  logic [SIZE_W-1:0] bsize = 2'h0;
  logic [ADDR_W-1:0] pc = 14'h0000, raddr, vbase, vaddr;
  logic [ADDR_W-1:0] starts [4] = '{14'h3800, 14'h3C00, 14'h3E00, 14'h3F00};
  logic [VEC_IDX_W-1:0] vidx = 5'h00;
  logic [2:0] ext;
  int mismatches = 0;
  int samples_checked = 0;
  int n;
`define CHK(what, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("BAD %s expected %h seen %h", what, exp, got); \
    end \
  end
  ivr_vector_ctrl dut (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .boot_reset_fuse_n_in(brst_n), .boot_size_fuses_in(bsize),
    .app_section_boot_lock_n_in(alock_n), .boot_section_self_lock_n_in(block_n),
    .pc_in(pc), .instr_done_in(idone), .global_int_enable_in(gie),
    .vector_index_in(vidx), .irq_permit_out(permit), .change_holdoff_out(holdoff),
    .vector_table_select_out(sel), .ext_int_enable_out(ext), .reset_addr_out(raddr),
    .vector_base_out(vbase), .vector_addr_out(vaddr)
  );
  // free-running system clock, 100 ns period
  initial begin
    forever #50 mclk_in = ~mclk_in;
  end
  task automatic close_out();
    $display("checked %0d, mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", exp, rd)
  endtask
  // reset held five cycles, then long enough for the fuse synchroniser
  task automatic do_reset();
    @(posedge mclk_in);
    resetn_in <= 1'b0;
    repeat (5) @(posedge mclk_in);
    resetn_in <= 1'b1;
    repeat (8) @(posedge mclk_in);
  endtask
  // one retired instruction ends the holdoff after a select write
  task automatic pulse();
    @(posedge mclk_in);
    idone <= 1'b1;
    @(posedge mclk_in);
    idone <= 1'b0;
    repeat (2) @(negedge mclk_in);
  endtask
  task automatic move(input logic v);
    wr(GIC_OFFSET, 32'h01);
    wr(GIC_OFFSET, {30'h0, v, 1'b0});
    pulse();
  endtask
  task automatic pcchk(input logic [ADDR_W-1:0] p, input logic exp);
    @(posedge mclk_in);
    pc <= p;
    repeat (3) @(negedge mclk_in);
    `CHK("permit", exp, permit)
  endtask
  task automatic t_regs();
    rdchk(GIC_OFFSET, 32'h0);
    rdchk(STATUS_OFFSET, 32'h80);
    wr(8'h0C, 32'hFF);
    `CHK("pslverr", 1'b1, err)
    wr(GIC_OFFSET, 32'hFE);
    rdchk(GIC_OFFSET, 32'hE0);
    `CHK("ext", 3'h7, ext)
    wr(GIC_OFFSET, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_move();
    wr(GIC_OFFSET, 32'h01);
    @(negedge mclk_in);
    `CHK("holdoff", 1'b1, holdoff)
    `CHK("permit", 1'b0, permit)
    wr(GIC_OFFSET, 32'h02);
    rdchk(GIC_OFFSET, 32'h02);
    @(negedge mclk_in);
    `CHK("holdoff", 1'b1, holdoff)
    pulse();
    `CHK("holdoff", 1'b0, holdoff)
    `CHK("permit", 1'b1, permit)
    `CHK("sel", 1'b1, sel)
    `CHK("vbase", 14'h3800, vbase)
    `CHK("vaddr", 14'h3802, vaddr)
    `CHK("raddr", 14'h0000, raddr)
    @(posedge mclk_in);
    vidx <= 5'h13;
    repeat (2) @(negedge mclk_in);
    `CHK("vaddr", 14'h3828, vaddr)
    $display("t_move done");
  endtask
  // re-arming at the last edge of a window must give a full fresh one;
  // the re-arming access cycle is the first of the four held-off cycles,
  // so three more are seen after the write returns
  task automatic t_timeout();
    int cnt;
    wr(GIC_OFFSET, 32'h01);
    wr(GIC_OFFSET, 32'h01);
    cnt = 0;
    repeat (12) begin
      @(negedge mclk_in);
      if (holdoff === 1'b1) cnt++;
    end
    `CHK("holdoff cycles", 3, cnt)
    `CHK("permit", 1'b1, permit)
    rdchk(GIC_OFFSET, 32'h02);
    move(1'b0);
    `CHK("vbase", 14'h0000, vbase)
    `CHK("vaddr", 14'h0028, vaddr)
    $display("t_timeout done");
  endtask
  task automatic t_fuse();
    for (int s = 0; s < 4; s++) begin
      @(posedge mclk_in);
      brst_n <= 1'b0;
      bsize <= SIZE_W'(s);
      do_reset();
      @(negedge mclk_in);
      `CHK("raddr", starts[s], raddr)
    end
    @(posedge mclk_in);
    bsize <= 2'h0;
    vidx <= 5'h00;
    do_reset();
    @(negedge mclk_in);
    `CHK("raddr", 14'h3800, raddr)
    `CHK("vaddr", 14'h0002, vaddr)
    move(1'b1);
    `CHK("raddr", 14'h3800, raddr)
    `CHK("vaddr", 14'h3802, vaddr)
    $display("t_fuse done");
  endtask
  // both lock fuses programmed: the section without the vectors is muted
  task automatic t_lock();
    @(posedge mclk_in);
    brst_n <= 1'b1;
    alock_n <= 1'b0;
    block_n <= 1'b0;
    do_reset();
    pcchk(14'h0100, 1'b1);
    pcchk(14'h3900, 1'b0);
    move(1'b1);
    pcchk(14'h3900, 1'b1);
    pcchk(14'h0100, 1'b0);
    @(posedge mclk_in);
    gie <= 1'b0;
    pc <= 14'h3900;
    repeat (3) @(negedge mclk_in);
    `CHK("permit", 1'b0, permit)
    $display("t_lock done");
  endtask
  initial begin
    do_reset();
    t_regs();
    t_move();
    t_timeout();
    t_fuse();
    t_lock();
    close_out();
  end
`undef CHK
endmodule
`default_nettype wire
